//--- core/port_adc_result_selftest_regs.v
// Per-port threshold, current result and fault injection register slice
`timescale 1ns/100ps
`include "port_adc_consts.vh"

module port_adc_result_selftest_regs #(
    parameter REFRESH_CYCLES = `REFRESH_CYCLES  // Sample interval in clocks
) (
    input  wire        ref_clk,        // 100 MHz clock
    input  wire        rstn,           // Async reset, active low
    input  wire [3:0]  reg_addr,       // Register offset in the slice
    input  wire        reg_wr,         // Write strobe, one cycle
    input  wire        reg_rd,         // Read strobe, one cycle
    input  wire [15:0] reg_wdata,      // Write data
    output reg  [15:0] reg_rdata,      // Read data, valid with reg_rvalid
    output reg         reg_rvalid,     // Read answer pulse
    input  wire        port_powered,   // Port in power-up or power-on
    input  wire        adc_done,       // Converter has a new sample
    input  wire [11:0] adc_sample,     // Converter sample value
    output reg         adc_start,      // Conversion request pulse
    input  wire        outp_good_raw,  // Positive output comparator
    input  wire        outm_good_raw,  // Return output comparator
    output reg         outp_bad,       // Positive output power-bad to port
    output reg         outm_bad,       // Return output power-bad to port
    output reg  [7:0]  sig_threshold   // Hold-signature threshold to port
);

    // Host port: reg_wr or reg_rd is high for one clock with reg_addr
    // and reg_wdata; a write lands on that edge, a read answers one clock
    // later with reg_rvalid, and reg_rdata then holds until the next read.
    // Limitation: a sample handed in while unpowered is still stored, so
    // the converter must not complete a conversion it was not asked for.

    // Last count of the sample interval; the 32-bit value is cut to the
    // counter width on purpose, the longest interval fits in 18 bits
    localparam [31:0] REFRESH_LAST_W = REFRESH_CYCLES - 1;
    localparam [17:0] REFRESH_LAST   = REFRESH_LAST_W[17:0];

    // Held state of the slice
    reg  [11:0] result_r;
    reg         fresh_r;
    reg         overrun_r;
    reg  [1:0]  inject_r;
    reg  [17:0] refresh_cnt_r;
    reg  [1:0]  outp_sync_r;
    reg  [1:0]  outm_sync_r;

    // Next values from the combinational processes
    reg  [15:0] rdata_nxt;
    reg  [11:0] result_nxt;
    reg         fresh_nxt;
    reg         overrun_nxt;
    reg  [17:0] refresh_cnt_nxt;
    reg         adc_start_nxt;

    // Offset match for one register of the slice, so every decode of
    // the strobes compares the address the same way
    function addr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // Power-bad seen by the port: the comparator says bad, or the host
    // forces it for self-test; a forced bad cannot be masked by a good pin
    function pwr_bad;
        input good_sync;
        input force_bad;
        begin
            pwr_bad = !good_sync || force_bad;
        end
    endfunction

    // Strobe decode; writes to the result register or to unmapped
    // offsets match nothing and are dropped
    wire wr_thr  = reg_wr && addr_hit(reg_addr, `OFS_SIG_THRESHOLD_CFG);
    wire wr_inj  = reg_wr && addr_hit(reg_addr, `OFS_FAULT_INJECTION);
    wire rd_res  = reg_rd && addr_hit(reg_addr, `OFS_CURRENT_RESULT);

    // Host writes to the threshold register; reserved upper bits are
    // dropped here so they always read back as zero
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sig_threshold <= `THR_RESET;
        end else if (wr_thr) begin
            sig_threshold <= reg_wdata[`THR_MSB:0];
        end
    end

    // Host writes to the self-test register; only the two force bits
    // are stored, the reserved bits cost no flip-flops
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            inject_r <= `INJ_RESET;
        end else if (wr_inj) begin
            inject_r <= reg_wdata[`INJ_OUTM_BIT:`INJ_OUTP_BIT];
        end
    end

    // Next result state; a new sample wins over a clearing read in the
    // same cycle, so no event is ever lost
    always @* begin
        result_nxt  = result_r;
        fresh_nxt   = fresh_r;
        overrun_nxt = overrun_r;
        if (adc_done) begin
            result_nxt = adc_sample;
            fresh_nxt  = 1'b1;
        end else if (rd_res) begin
            fresh_nxt = 1'b0;
        end
        // Unread means fresh still set and not being read right now; a
        // sample landing on the read itself was not missed
        if (adc_done && fresh_r && !rd_res) begin
            overrun_nxt = 1'b1;
        end else if (rd_res) begin
            overrun_nxt = 1'b0;
        end
    end

    // Result and flag registers
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            result_r  <= `RES_RESET;
            fresh_r   <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            result_r  <= result_nxt;
            fresh_r   <= fresh_nxt;
            overrun_r <= overrun_nxt;
        end
    end

    // Fixed-interval sample request; counter idles when unpowered so
    // the first sample comes one full interval after power-up
    always @* begin
        refresh_cnt_nxt = refresh_cnt_r + 18'h00001;
        adc_start_nxt   = 1'b0;
        if (!port_powered) begin
            refresh_cnt_nxt = 18'h00000;
        end else if (refresh_cnt_r == REFRESH_LAST) begin
            refresh_cnt_nxt = 18'h00000;
            adc_start_nxt   = 1'b1;
        end
    end

    // Interval counter and request pulse; the pulse is registered so the
    // converter never sees a decode glitch
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            refresh_cnt_r <= 18'h00000;
            adc_start     <= 1'b0;
        end else begin
            refresh_cnt_r <= refresh_cnt_nxt;
            adc_start     <= adc_start_nxt;
        end
    end

    // Comparators are analog and asynchronous: two-stage synchronisers,
    // and only the second stage is ever read by logic
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outp_sync_r <= 2'h0;
            outm_sync_r <= 2'h0;
        end else begin
            outp_sync_r <= {outp_sync_r[0], outp_good_raw};
            outm_sync_r <= {outm_sync_r[0], outm_good_raw};
        end
    end

    // Power-bad decision from the second synchroniser stage
    wire outp_bad_nxt = pwr_bad(outp_sync_r[1], inject_r[`INJ_OUTP_BIT]);
    wire outm_bad_nxt = pwr_bad(outm_sync_r[1], inject_r[`INJ_OUTM_BIT]);

    // Power-bad outputs reset to bad, the safe state, and stay so for
    // three clocks after reset until the synchronisers fill
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outp_bad <= 1'b1;
            outm_bad <= 1'b1;
        end else begin
            outp_bad <= outp_bad_nxt;
            outm_bad <= outm_bad_nxt;
        end
    end

    // Read mux; reserved bits and unmapped offsets read as zero
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `OFS_SIG_THRESHOLD_CFG: begin
                rdata_nxt = {8'h00, sig_threshold};
            end
            `OFS_CURRENT_RESULT: begin
                rdata_nxt = {2'h0, overrun_r, fresh_r, result_r};
            end
            `OFS_FAULT_INJECTION: begin
                rdata_nxt = {14'h0000, inject_r};
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

endmodule

//--- core/port_adc_consts.vh
// Register map, field positions and timing for the port ADC register slice
`ifndef PORT_ADC_CONSTS_VH
`define PORT_ADC_CONSTS_VH

// Register offsets within one port slice (low address nibble)
`define OFS_SIG_THRESHOLD_CFG  4'h5
`define OFS_CURRENT_RESULT     4'h6
`define OFS_FAULT_INJECTION    4'h7

// Threshold configuration fields
`define THR_MSB                7
`define THR_RESET              8'h00

// Current result fields
`define RES_MSB                11
`define RES_FRESH_BIT          12
`define RES_OVERRUN_BIT        13
`define RES_RESET              12'h000

// Fault injection fields
`define INJ_OUTP_BIT           0
`define INJ_OUTM_BIT           1
`define INJ_RESET              2'h0

// Refresh timing: interval in microseconds, clock rate in MHz
`define REFRESH_TIME_US        1800
`define CLK_RATE_MHZ           100
`define REFRESH_CYCLES         (`REFRESH_TIME_US * `CLK_RATE_MHZ)

`endif

//--- verification/port_adc_props.sv
// Concurrent checks on the port ADC register slice ports
`timescale 1ns/100ps
`include "port_adc_consts.vh"
module port_adc_props #(
    parameter REFRESH_CYCLES = `REFRESH_CYCLES
) (
    input logic        ref_clk,
    input logic        rstn,
    input logic [3:0]  reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic        reg_rvalid,
    input logic        port_powered,
    input logic        adc_done,
    input logic [11:0] adc_sample,
    input logic        adc_start,
    input logic        outp_good_raw,
    input logic        outm_good_raw,
    input logic        outp_bad,
    input logic        outm_bad,
    input logic [7:0]  sig_threshold
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Result register read strobe
    wire rd6 = reg_rd && reg_addr == 4'h6;
    property p_rv; reg_rvalid == $past(reg_rd); endproperty
    a_rv: assert property (p_rv) else $error("read answer timing");
    property p_thr; reg_wr && reg_addr == 4'h5 |=>
        {8'h00, sig_threshold} == ($past(reg_wdata) & 16'h00FF); endproperty
    a_thr: assert property (p_thr) else $error("threshold");
    property p_new; adc_done ##1 !adc_done && !rd6 ##1 rd6 |=>
        reg_rdata[15:14] == 0 &&
        reg_rdata[12:0] == {1'b1, $past(adc_sample, 3)}; endproperty
    a_new: assert property (p_new) else $error("fresh result");
    property p_ovr; adc_done && !reg_rd ##1 !reg_rd ##1 adc_done && !reg_rd
        ##1 !reg_rd ##1 rd6 |=> reg_rdata[13]; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun");
    property p_clr; rd6 && !adc_done ##1 !adc_done ##1 rd6 |=>
        reg_rdata[13:12] == 2'b00; endproperty
    a_clr: assert property (p_clr) else $error("flag clear");
    property p_res; reg_rd && reg_addr == 4'h7 |=> reg_rdata[15:2] == 0;
    endproperty
    a_res: assert property (p_res) else $error("reserved bits");
    property p_injp; reg_wr && reg_addr == 4'h7 && reg_wdata[0] |-> ##2 outp_bad;
    endproperty
    a_injp: assert property (p_injp) else $error("outp inject");
    property p_injm; reg_wr && reg_addr == 4'h7 && reg_wdata[1] |-> ##2 outm_bad;
    endproperty
    a_injm: assert property (p_injm) else $error("outm inject");
    property p_start; adc_start |=> !adc_start [*8]; endproperty
    a_start: assert property (p_start) else $error("start spacing");
    // Cycles since the last request, counted only while powered
    int   gap_cnt;
    logic gap_valid;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt   <= 0;
            gap_valid <= 1'b0;
        end else if (!port_powered) begin
            gap_cnt   <= 0;
            gap_valid <= 1'b0;
        end else if (adc_start) begin
            gap_cnt   <= 1;
            gap_valid <= 1'b1;
        end else begin
            gap_cnt   <= gap_cnt + 1;
        end
    end
    property p_period; adc_start && gap_valid |-> gap_cnt == REFRESH_CYCLES;
    endproperty
    a_period: assert property (p_period) else $error("start period");
    property p_idle; !port_powered |=> !adc_start; endproperty
    a_idle: assert property (p_idle) else $error("start unpowered");
    c_ovr: cover property (reg_rvalid && reg_rdata[13]);
    c_bad: cover property (outp_bad && outm_bad);
    c_start: cover property (adc_start);
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the port ADC register slice
`timescale 1ns/100ps
module tb_top;
    localparam REFRESH_CYCLES = 20;
    logic        ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, adc_done = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic        port_powered = 0, adc_start, reg_rvalid, outp_bad, outm_bad;
    logic        outp_good_raw = 1, outm_good_raw = 1;
    logic [11:0] adc_sample = 12'h000;
    logic [7:0]  sig_threshold;
    int          error_cnt = 0, compares = 0, n = 0;
    port_adc_result_selftest_regs #(
        .REFRESH_CYCLES(REFRESH_CYCLES)
    ) dut (
        .ref_clk       (ref_clk),
        .rstn          (rstn),
        .reg_addr      (reg_addr),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_wdata     (reg_wdata),
        .reg_rdata     (reg_rdata),
        .reg_rvalid    (reg_rvalid),
        .port_powered  (port_powered),
        .adc_done      (adc_done),
        .adc_sample    (adc_sample),
        .adc_start     (adc_start),
        .outp_good_raw (outp_good_raw),
        .outm_good_raw (outm_good_raw),
        .outp_bad      (outp_bad),
        .outm_bad      (outm_bad),
        .sig_threshold (sig_threshold)
    );
    initial forever #5 ref_clk = ~ref_clk;
    // Compare, tally, report
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", nm, exp, got);
            error_cnt++;
        end
    endtask
    // Bus strobes are one cycle wide, so each task spends two edges
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] exp);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 chk("rdata", exp, reg_rdata);
        chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
    endtask
    task automatic adc(logic [11:0] s);
        @(posedge ref_clk);
        {adc_done, adc_sample} <= {1'b1, s};
        @(posedge ref_clk);
        adc_done <= 0;
    endtask
    task automatic end_sim;
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1;
        repeat (4) @(posedge ref_clk);
        #1 chk("bad", 16'h0000, {14'h0, outp_bad, outm_bad});
        rd(4'h7, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(4'h5, 16'hFFA5);
        rd(4'h5, 16'h00A5);
        chk("thr", 16'h00A5, {8'h00, sig_threshold});
        wr(4'h6, 16'hFFFF);
        rd(4'h6, 16'h0000);
        adc(12'h123);
        rd(4'h6, 16'h1123);
        rd(4'h6, 16'h0123);
        adc(12'hABC);
        adc(12'hFFF);
        rd(4'h6, 16'h3FFF);
        rd(4'h6, 16'h0FFF);
        wr(4'h7, 16'hFFFF);
        rd(4'h7, 16'h0003);
        chk("bad", 16'h0003, {14'h0, outp_bad, outm_bad});
        wr(4'h7, 16'h0001);
        rd(4'h7, 16'h0001);
        chk("bad", 16'h0002, {14'h0, outp_bad, outm_bad});
        wr(4'h7, 16'h0000);
        outm_good_raw <= 0;
        rd(4'h7, 16'h0000);
        repeat (2) @(posedge ref_clk);
        #1 chk("bad", 16'h0001, {14'h0, outp_bad, outm_bad});
        // Count edges from power-up to the first request, then from the
        // first to the second; both must be one full interval
        @(posedge ref_clk);
        port_powered <= 1;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                #1 n++;
            end while (n < 100 && adc_start !== 1'b1);
            chk("start", 16'(REFRESH_CYCLES), n[15:0]);
        end
        // Power removed: no request may follow
        @(posedge ref_clk);
        port_powered <= 0;
        n = 0;
        repeat (30) begin
            @(posedge ref_clk);
            #1 if (adc_start !== 1'b0) n++;
        end
        chk("idle start", 16'h0000, n[15:0]);
        end_sim();
    end
endmodule
bind port_adc_result_selftest_regs port_adc_props #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
) u_props (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .reg_rvalid    (reg_rvalid),
    .port_powered  (port_powered),
    .adc_done      (adc_done),
    .adc_sample    (adc_sample),
    .adc_start     (adc_start),
    .outp_good_raw (outp_good_raw),
    .outm_good_raw (outm_good_raw),
    .outp_bad      (outp_bad),
    .outm_bad      (outm_bad),
    .sig_threshold (sig_threshold)
);
